// ---- core/rtc_channel.sv ----
// one 16-bit reload timer channel: timer, event counter, two-phase decode
`include "rtc_defines.svh"

module rtc_channel #(
    parameter int CHANNEL_INDEX = 3     // 0 to 4; neighbour wiring wraps 4 to 0
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [31:0]  reg_rdata,
    input  wire logic         prescale_tick,
    input  wire logic         timer_b2_event,
    input  wire logic         prev_chan_event,
    input  wire logic         next_chan_event,
    input  wire logic         channel_in_pin,
    input  wire logic         channel_out_pin_in,
    output logic              channel_out_pin_out,
    output logic              channel_out_pin_oe,
    input  wire logic         z_phase_pin,
    output logic              irq_pulse,
    output logic              wrap_event
);
    import rtc_pkg::*;

    rtc_regs_t r_reg;
    rtc_regs_t r_next;

    // ------------------------------------------------------------
    // decoded configuration
    // ------------------------------------------------------------
    logic       is_timer;
    logic       is_event;
    logic       two_phase;
    logic       quad;
    logic       z_active;
    logic       a_lvl;
    logic       b_lvl;
    logic       z_lvl;
    logic       a_rise;
    logic       a_fall;
    logic       b_edge;
    logic       z_edge;
    logic       gate_ok;
    logic       src;
    logic       up;
    logic       go;
    logic       wrap;
    logic       wr_count;

    // configuration and synchronised pin levels
    always_comb
    begin
        is_timer  = (r_reg.mode[1:0] == RTC_TIMER);
        is_event  = (r_reg.mode[1:0] == RTC_EVENT);
        two_phase = (CHANNEL_INDEX >= 2) && (CHANNEL_INDEX <= 4) && is_event
                    && r_reg.dirctl[`RTC_DIR_TWOPH]
                    && (r_reg.trig[1:0] == RTC_SRC_PIN);
        quad      = (CHANNEL_INDEX == 4)
                    || ((CHANNEL_INDEX == 3) && r_reg.mode[`RTC_MODE_QUAD]);
        z_active  = (CHANNEL_INDEX == 3) && two_phase && quad
                    && r_reg.mode[`RTC_MODE_FREE] && r_reg.trig[`RTC_TRIG_ZEN];
        a_lvl     = r_reg.a_sync[1];
        b_lvl     = r_reg.b_sync[1];
        z_lvl     = r_reg.z_sync[1];
        a_rise    = a_lvl && !r_reg.a_d;
        a_fall    = !a_lvl && r_reg.a_d;
        b_edge    = b_lvl != r_reg.b_d;
        z_edge    = r_reg.edge_polarity_bit ? (z_lvl && !r_reg.z_d) : (!z_lvl && r_reg.z_d);
        wr_count  = reg_wr && (reg_addr == `RTC_OFF_COUNT);
    end

    // ------------------------------------------------------------
    // count source, direction and count enable
    // ------------------------------------------------------------
    always_comb
    begin
        gate_ok = 1'b1;
        src     = 1'b0;
        up      = 1'b0;
        if (r_reg.mode[`RTC_MODE_GATE1])
        begin
            gate_ok = (a_lvl == r_reg.mode[`RTC_MODE_GATE0]);
        end
        if (is_timer)
        begin
            src = prescale_tick && gate_ok;
        end
        else if (is_event && two_phase && quad)
        begin
            src = a_rise || a_fall || b_edge;
            if (a_rise && b_lvl)
            begin
                up = 1'b1;
            end
            else if (a_fall && b_lvl)
            begin
                up = 1'b0;
            end
            else
            begin
                up = r_reg.quad_up;
            end
        end
        else if (is_event && two_phase)
        begin
            src = b_lvl && (a_rise || a_fall);
            up  = a_rise;
        end
        else if (is_event)
        begin
            case (r_reg.trig[1:0])
                RTC_SRC_PIN:  src = r_reg.mode[`RTC_MODE_EDGE] ? a_rise : a_fall;
                RTC_SRC_B2:   src = timer_b2_event;
                RTC_SRC_PREV: src = prev_chan_event;
                RTC_SRC_NEXT: src = next_chan_event;
                default:      src = 1'b0;
            endcase
            up = r_reg.mode[`RTC_MODE_DIRSRC] ? b_lvl
                                              : r_reg.dirctl[`RTC_DIR_UP];
        end
        // zero count keeps the counter still except in two-phase mode
        go   = r_reg.run && src && ((r_reg.reload != 16'h0000) || two_phase);
        wrap = up ? (r_reg.counter == `RTC_CNT_MAX) : (r_reg.counter == 16'h0000);
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        r_next           = r_reg;
        r_next.irq       = r_reg.irq_extra;
        r_next.irq_extra = 1'b0;
        r_next.wrap_evt  = 1'b0;
        r_next.rdata     = 16'h0000;
        // two-flop synchronisers for pins
        r_next.a_sync    = {r_reg.a_sync[0], channel_in_pin};
        r_next.b_sync    = {r_reg.b_sync[0], channel_out_pin_in};
        r_next.z_sync    = {r_reg.z_sync[0], z_phase_pin};
        r_next.a_d       = a_lvl;
        r_next.b_d       = b_lvl;
        r_next.z_d       = z_lvl;
        if (two_phase && quad && (a_rise || a_fall) && b_lvl)
        begin
            r_next.quad_up = a_rise;
        end
        // counting step
        if (go)
        begin
            r_next.state = RTC_COUNTING;
            if (z_active && r_reg.z_pend)
            begin
                r_next.counter = 16'h0000;
                if (wrap)
                begin
                    r_next.irq       = 1'b1;
                    r_next.irq_extra = 1'b1;
                    r_next.wrap_evt  = 1'b1;
                end
            end
            else if (wrap)
            begin
                if (is_event && r_reg.mode[`RTC_MODE_FREE])
                begin
                    r_next.counter = up ? 16'h0000 : `RTC_CNT_MAX;
                end
                else
                begin
                    r_next.counter = r_reg.reload;
                end
                r_next.irq      = 1'b1;
                r_next.wrap_evt = 1'b1;
                if (r_reg.mode[`RTC_MODE_PULSE])
                begin
                    r_next.out_lvl = !r_reg.out_lvl;
                end
            end
            else
            begin
                r_next.counter = up ? r_reg.counter + 16'h0001
                                    : r_reg.counter - 16'h0001;
            end
        end
        // z edge detection; a new edge wins over consumption
        if (go && z_active && r_reg.z_pend)
        begin
            r_next.z_pend = 1'b0;
        end
        if (z_active && z_edge)
        begin
            r_next.z_pend = 1'b1;
        end
        else if (!z_active)
        begin
            r_next.z_pend = 1'b0;
        end
        // register writes
        if (reg_wr)
        begin
            case (reg_addr)
                `RTC_OFF_COUNT:
                begin
                    r_next.reload = reg_wdata[15:0];
                    if (r_reg.state != RTC_COUNTING)
                    begin
                        r_next.counter = reg_wdata[15:0];
                    end
                end
                `RTC_OFF_MODE:  r_next.mode   = reg_wdata[8:0];
                `RTC_OFF_RUN:
                begin
                    r_next.run = reg_wdata[0];
                    if (!reg_wdata[0])
                    begin
                        r_next.state = RTC_STOPPED;
                    end
                    else if (!r_reg.run)
                    begin
                        r_next.state = RTC_ARMED;
                    end
                end
                `RTC_OFF_DIR:   r_next.dirctl = reg_wdata[1:0];
                `RTC_OFF_TRIG:  r_next.trig   = reg_wdata[2:0];
                `RTC_OFF_ZCTL:  r_next.edge_polarity_bit    = reg_wdata[0];
                default:        r_next.run    = r_reg.run;
            endcase
        end
        // output held low while stopped
        if (!r_next.run)
        begin
            r_next.out_lvl = 1'b0;
        end
        // register reads, data valid the next cycle
        if (reg_rd)
        begin
            case (reg_addr)
                `RTC_OFF_COUNT:  r_next.rdata = r_reg.counter;
                `RTC_OFF_MODE:   r_next.rdata = {7'h00, r_reg.mode};
                `RTC_OFF_RUN:    r_next.rdata = {15'h0000, r_reg.run};
                `RTC_OFF_DIR:    r_next.rdata = {14'h0000, r_reg.dirctl};
                `RTC_OFF_TRIG:   r_next.rdata = {13'h0000, r_reg.trig};
                `RTC_OFF_ZCTL:   r_next.rdata = {15'h0000, r_reg.edge_polarity_bit};
                `RTC_OFF_STATUS: r_next.rdata = {11'h000, r_reg.quad_up, r_reg.out_lvl,
                                                 r_reg.z_pend, r_reg.state};
                default:         r_next.rdata = 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            r_reg         <= '0;
            r_reg.state   <= RTC_STOPPED;
            r_reg.counter <= `RTC_RST_COUNT;
            r_reg.reload  <= `RTC_RST_COUNT;
            r_reg.mode    <= `RTC_RST_MODE;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // pin is an input whenever it carries direction or phase B
    assign channel_out_pin_out = r_reg.out_lvl;
    assign channel_out_pin_oe  = r_reg.mode[`RTC_MODE_PULSE] && !two_phase
                                 && !(is_event && r_reg.mode[`RTC_MODE_DIRSRC]);
    assign irq_pulse           = r_reg.irq;
    assign wrap_event          = r_reg.wrap_evt;
    assign reg_rdata           = {16'h0000, r_reg.rdata};

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    chk_stop_holds: assert property (
        (!r_reg.run && !wr_count) |=> (r_reg.counter == $past(r_reg.counter)))
        else $error("counter moved while stopped");

    chk_out_low_stop: assert property (
        !r_reg.run |-> !channel_out_pin_out)
        else $error("pulse output high while stopped");

    chk_zero_silent: assert property (
        (r_reg.reload == 16'h0000 && !two_phase && !r_reg.irq_extra && !wr_count)
        |=> !irq_pulse)
        else $error("interrupt with zero count");

    chk_live_read: assert property (
        (reg_rd && reg_addr == `RTC_OFF_COUNT)
        |=> (reg_rdata[15:0] == $past(r_reg.counter)))
        else $error("count read not live value");

    chk_write_stopped: assert property (
        (wr_count && r_reg.state != RTC_COUNTING)
        |=> (r_reg.counter == $past(reg_wdata[15:0])
             && r_reg.reload == $past(reg_wdata[15:0])))
        else $error("stopped write did not load counter");

    chk_write_running: assert property (
        (wr_count && r_reg.state == RTC_COUNTING && !go)
        |=> (r_reg.counter == $past(r_reg.counter)
             && r_reg.reload == $past(reg_wdata[15:0])))
        else $error("running write disturbed counter");

    chk_timer_reload: assert property (
        (is_timer && go && r_reg.counter == 16'h0000 && !wr_count)
        |=> (r_reg.counter == $past(r_reg.reload) && irq_pulse))
        else $error("timer underflow did not reload");

    chk_event_free: assert property (
        (is_event && go && wrap && r_reg.mode[`RTC_MODE_FREE] && !wr_count
         && !(z_active && r_reg.z_pend))
        |=> (r_reg.counter == ($past(up) ? 16'h0000 : `RTC_CNT_MAX)))
        else $error("free-running wrap loaded reload");

    chk_z_double: assert property (
        (go && z_active && r_reg.z_pend && wrap) |=> irq_pulse ##1 irq_pulse)
        else $error("z reset with wrap missed second interrupt");

    chk_pulse_toggle: assert property (
        (go && wrap && r_reg.mode[`RTC_MODE_PULSE] && !reg_wr
         && !(z_active && r_reg.z_pend))
        |=> (channel_out_pin_out != $past(channel_out_pin_out)))
        else $error("pulse output did not toggle on wrap");

    // normal two-phase: an A rising edge with B high steps the counter up by one
    chk_normal_up: assert property (
        (two_phase && !quad && go && a_rise && !wrap && !wr_count)
        |=> (r_reg.counter == $past(r_reg.counter) + 16'h0001))
        else $error("normal two-phase rising edge did not count up");

    cov_timer_underflow: cover property (is_timer && go && wrap);
    cov_event_overflow:  cover property (is_event && go && wrap && up);
    cov_quad_count:      cover property (two_phase && quad && go);
    cov_z_reset:         cover property (go && z_active && r_reg.z_pend);
    cov_gate_closed:     cover property (is_timer && prescale_tick && !gate_ok);

endmodule // rtc_channel

// ---- core/rtc_defines.svh ----
// register offsets, field positions and reset values of the reload timer channel
`ifndef RTC_DEFINES_SVH
`define RTC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTC_OFF_COUNT   8'h00
`define RTC_OFF_MODE    8'h04
`define RTC_OFF_RUN     8'h08
`define RTC_OFF_DIR     8'h0C
`define RTC_OFF_TRIG    8'h10
`define RTC_OFF_ZCTL    8'h14
`define RTC_OFF_STATUS  8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RTC_MODE_PULSE  2
`define RTC_MODE_GATE0  3
`define RTC_MODE_GATE1  4
`define RTC_MODE_EDGE   5
`define RTC_MODE_DIRSRC 6
`define RTC_MODE_FREE   7
`define RTC_MODE_QUAD   8
`define RTC_DIR_UP      0
`define RTC_DIR_TWOPH   1
`define RTC_TRIG_ZEN    2

// ----------------------------------------------------------------
// reset values and count limit
// ----------------------------------------------------------------
`define RTC_RST_COUNT   16'h0000
`define RTC_RST_MODE    9'h000
`define RTC_CNT_MAX     16'hFFFF

`endif

// ---- core/rtc_pkg.sv ----
// types shared by the reload timer channel
package rtc_pkg;

    // channel run state, gray coded along stopped, armed, counting
    typedef enum logic [1:0] {
        RTC_STOPPED  = 2'h0,
        RTC_ARMED    = 2'h1,
        RTC_COUNTING = 2'h3
    } rtc_state_t;

    // operating modes selected by the two low mode bits
    typedef enum logic [1:0] {
        RTC_TIMER   = 2'h0,
        RTC_EVENT   = 2'h1,
        RTC_ONESHOT = 2'h2,
        RTC_PWM     = 2'h3
    } rtc_mode_t;

    // event counter source select
    typedef enum logic [1:0] {
        RTC_SRC_PIN  = 2'h0,
        RTC_SRC_B2   = 2'h1,
        RTC_SRC_PREV = 2'h2,
        RTC_SRC_NEXT = 2'h3
    } rtc_src_t;

    // complete state of one channel
    typedef struct packed {
        rtc_state_t  state;
        logic [15:0] counter;
        logic [15:0] reload;
        logic [8:0]  mode;
        logic        run;
        logic [1:0]  dirctl;
        logic [2:0]  trig;
        logic        edge_polarity_bit;
        logic [1:0]  a_sync;
        logic [1:0]  b_sync;
        logic [1:0]  z_sync;
        logic        a_d;
        logic        b_d;
        logic        z_d;
        logic        quad_up;
        logic        z_pend;
        logic        out_lvl;
        logic        irq;
        logic        irq_extra;
        logic        wrap_evt;
        logic [15:0] rdata;
    } rtc_regs_t;

endpackage

// ---- bench/rtc_far_side.sv ----
// far side of the channel: tick source, neighbour timers, encoder phases and Z pin
module rtc_far_side (
    input  wire logic       core_clk,
    input  wire logic [1:0] pulse_sel,
    input  wire logic       pulse_go,
    input  wire logic       step_go,
    input  wire logic       step_up,
    input  wire logic       z_go,
    output logic            prescale_tick,
    output logic            timer_b2_event,
    output logic            prev_chan_event,
    output logic            next_chan_event,
    output logic            phase_a,
    output logic            phase_b,
    output logic            z_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] sel_q  = 2'h0;
    logic       go_q   = 1'b0;
    logic [1:0] pos    = 2'h0;  // gray position, up runs 01 11 10 00
    logic [4:0] z_left = 5'h00;

    // -------------------------------------------
    // source pulses and encoder stepping
    // -------------------------------------------
    // one request becomes one single-cycle pulse on the chosen source
    always_ff @(posedge core_clk)
    begin
        sel_q  <= pulse_sel;
        go_q   <= pulse_go;
        pos    <= step_go ? (step_up ? pos + 2'h1 : pos - 2'h1) : pos;
        z_left <= z_go ? 5'h10 : (z_left != 5'h00 ? z_left - 5'h01 : 5'h00);
    end

    // decode of the pulse request
    assign prescale_tick   = go_q && sel_q == 2'h0;
    assign timer_b2_event  = go_q && sel_q == 2'h1;
    assign prev_chan_event = go_q && sel_q == 2'h2;
    assign next_chan_event = go_q && sel_q == 2'h3;
    // Z held far longer than one encoder step
    assign z_pin = z_left != 5'h00;

    // phase levels from the position
    always_comb
    begin
        case (pos)
            2'h0:    {phase_a, phase_b} = 2'h1;
            2'h1:    {phase_a, phase_b} = 2'h3;
            2'h2:    {phase_a, phase_b} = 2'h2;
            default: {phase_a, phase_b} = 2'h0;
        endcase
    end
endmodule // rtc_far_side

// ---- bench/test_reload_timer_event_counter.sv ----
// self-checking testbench of the reload timer channel
`include "rtc_defines.svh"

module test_reload_timer_event_counter;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk = 1'b0;
    logic        reset, reg_wr, reg_rd, pulse_go, step_go, step_up, z_go;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [1:0]  pulse_sel;
    logic        tick, b2_ev, prev_ev, next_ev, ph_a, ph_b, z_pin;
    logic        out_lvl, out_oe, out_wire, irq_pulse, wrap_event;
    int          n_mismatch = 0;
    int          checked = 0;
    int          n_irq = 0;
    int          n_wrap = 0;

    always #12.5 core_clk = ~core_clk;
    // out pin level: channel when driving, else the encoder phase B
    assign out_wire = out_oe ? out_lvl : ph_b;

    rtc_channel #(.CHANNEL_INDEX(3)) i_dut (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prescale_tick(tick),
        .timer_b2_event(b2_ev), .prev_chan_event(prev_ev), .next_chan_event(next_ev),
        .channel_in_pin(ph_a), .channel_out_pin_in(out_wire),
        .channel_out_pin_out(out_lvl), .channel_out_pin_oe(out_oe),
        .z_phase_pin(z_pin), .irq_pulse(irq_pulse), .wrap_event(wrap_event));

    rtc_far_side i_far (
        .core_clk(core_clk), .pulse_sel(pulse_sel), .pulse_go(pulse_go),
        .step_go(step_go), .step_up(step_up), .z_go(z_go), .prescale_tick(tick),
        .timer_b2_event(b2_ev), .prev_chan_event(prev_ev), .next_chan_event(next_ev),
        .phase_a(ph_a), .phase_b(ph_b), .z_pin(z_pin));

    // count interrupt and wrap pulses
    always @(posedge core_clk)
    begin
        n_irq  <= n_irq + (irq_pulse === 1'b1 ? 1 : 0);
        n_wrap <= n_wrap + (wrap_event === 1'b1 ? 1 : 0);
    end

    // ---------------------------------------------
    // bus and stimulus tasks
    // ---------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic pulse(input logic [1:0] s, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            pulse_sel <= s;
            pulse_go  <= 1'b1;
            @(posedge core_clk);
            pulse_go  <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
    endtask

    task automatic step(input logic up, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            step_up <= up;
            step_go <= 1'b1;
            @(posedge core_clk);
            step_go <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask

    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    task automatic reset_values();
        logic [31:0] d;
        rd(`RTC_OFF_COUNT, d); check("count", d, 32'h0000_0000);
        rd(`RTC_OFF_RUN, d); check("run", d, 32'h0000_0000);
        wr(8'h1C, 32'h0000_FFFF);
        rd(8'h1C, d); check("unmapped", d, 32'h0000_0000);
        check("out level", {31'h0, out_lvl}, 32'h0000_0000);
    endtask

    task automatic timer_reload();
        logic [31:0] d;
        int          i0;
        i0 = n_irq;
        wr(`RTC_OFF_MODE, 32'h0000_0004);
        wr(`RTC_OFF_COUNT, 32'h0000_0002);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        wr(`RTC_OFF_COUNT, 32'h0000_0003);
        rd(`RTC_OFF_COUNT, d); check("armed write", d, 32'h0000_0003);
        check("timer oe", {31'h0, out_oe}, 32'h0000_0001);
        pulse(2'h0, 1);
        rd(`RTC_OFF_COUNT, d); check("live count", d, 32'h0000_0002);
        pulse(2'h0, 3);
        rd(`RTC_OFF_COUNT, d); check("reloaded", d, 32'h0000_0003);
        check("timer irq", 32'(n_irq - i0), 32'h0000_0001);
        check("out toggled", {31'h0, out_lvl}, 32'h0000_0001);
        wr(`RTC_OFF_COUNT, 32'h0000_0005);
        pulse(2'h0, 1);
        rd(`RTC_OFF_COUNT, d); check("running write", d, 32'h0000_0002);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
        check("out stopped", {31'h0, out_lvl}, 32'h0000_0000);
        pulse(2'h0, 2);
        rd(`RTC_OFF_COUNT, d); check("stopped", d, 32'h0000_0002);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        pulse(2'h0, 3);
        rd(`RTC_OFF_COUNT, d); check("new reload", d, 32'h0000_0005);
        check("timer irq 2", 32'(n_irq - i0), 32'h0000_0002);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
    endtask

    task automatic zero_count();
        logic [31:0] d;
        int          i0;
        i0 = n_irq;
        wr(`RTC_OFF_COUNT, 32'h0000_0000);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        pulse(2'h0, 3);
        rd(`RTC_OFF_COUNT, d); check("zero count", d, 32'h0000_0000);
        check("zero irq", 32'(n_irq - i0), 32'h0000_0000);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
    endtask

    task automatic event_sources();
        logic [31:0] d;
        int          i0;
        int          w0;
        i0 = n_irq;
        w0 = n_wrap;
        wr(`RTC_OFF_MODE, 32'h0000_0005);
        wr(`RTC_OFF_DIR, 32'h0000_0001);
        for (int s = 1; s <= 3; s++)
        begin
            wr(`RTC_OFF_TRIG, 32'(s));
            wr(`RTC_OFF_COUNT, 32'h0000_FFFE);
            wr(`RTC_OFF_RUN, 32'h0000_0001);
            pulse(2'((s % 3) + 1), 1);
            rd(`RTC_OFF_COUNT, d); check("other source", d, 32'h0000_FFFE);
            pulse(2'(s), 2);
            rd(`RTC_OFF_COUNT, d); check("overflow", d, 32'h0000_FFFE);
            wr(`RTC_OFF_RUN, 32'h0000_0000);
            check("event out", {31'h0, out_lvl}, 32'h0000_0000);
        end
        check("event irq", 32'(n_irq - i0), 32'h0000_0003);
        check("wrap pulses", 32'(n_wrap - w0), 32'h0000_0003);
    endtask

    task automatic quadrature();
        logic [31:0] d;
        int          i0;
        int          w0;
        wr(`RTC_OFF_MODE, 32'h0000_0181);
        wr(`RTC_OFF_DIR, 32'h0000_0002);
        wr(`RTC_OFF_TRIG, 32'h0000_0004);
        wr(`RTC_OFF_ZCTL, 32'h0000_0001);
        wr(`RTC_OFF_COUNT, 32'h0000_0000);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        step(1'b1, 5);
        rd(`RTC_OFF_COUNT, d); check("quad up", d, 32'h0000_0005);
        check("quad oe", {31'h0, out_oe}, 32'h0000_0000);
        step(1'b0, 2);
        rd(`RTC_OFF_COUNT, d); check("quad down", d, 32'h0000_0003);
        // second pass arms Z with the counter at zero, so reset and wrap coincide
        for (int k = 0; k < 2; k++)
        begin
            i0 = n_irq;
            w0 = n_wrap;
            @(posedge core_clk);
            z_go <= 1'b1;
            @(posedge core_clk);
            z_go <= 1'b0;
            repeat (20) @(posedge core_clk);
            step(1'b0, 1);
            rd(`RTC_OFF_COUNT, d); check("z reset", d, 32'h0000_0000);
            check("z irq", 32'(n_irq - i0), 32'(2 * k));
            check("z wrap", 32'(n_wrap - w0), 32'(k));
        end
        i0 = n_irq;
        step(1'b0, 1);
        rd(`RTC_OFF_COUNT, d); check("free wrap", d, 32'h0000_FFFF);
        check("wrap irq", 32'(n_irq - i0), 32'h0000_0001);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
    endtask

    task automatic two_phase_normal();
        logic [31:0] d;
        wr(`RTC_OFF_MODE, 32'h0000_0001);
        wr(`RTC_OFF_COUNT, 32'h0000_0010);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        step(1'b1, 4);
        rd(`RTC_OFF_COUNT, d); check("normal up", d, 32'h0000_0011);
        step(1'b0, 4);
        rd(`RTC_OFF_COUNT, d); check("normal down", d, 32'h0000_0010);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
    endtask

    task automatic gate_and_dir_pin();
        logic [31:0] d;
        wr(`RTC_OFF_MODE, 32'h0000_0018);
        wr(`RTC_OFF_COUNT, 32'h0000_0003);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        pulse(2'h0, 2);
        rd(`RTC_OFF_COUNT, d); check("gate closed", d, 32'h0000_0003);
        step(1'b1, 1);
        pulse(2'h0, 2);
        rd(`RTC_OFF_COUNT, d); check("gate open", d, 32'h0000_0001);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
        wr(`RTC_OFF_MODE, 32'h0000_0045);
        wr(`RTC_OFF_TRIG, 32'h0000_0001);
        wr(`RTC_OFF_COUNT, 32'h0000_0005);
        wr(`RTC_OFF_RUN, 32'h0000_0001);
        pulse(2'h1, 1);
        rd(`RTC_OFF_COUNT, d); check("pin up", d, 32'h0000_0006);
        check("dir pin oe", {31'h0, out_oe}, 32'h0000_0000);
        step(1'b1, 1);
        pulse(2'h1, 2);
        rd(`RTC_OFF_COUNT, d); check("pin down", d, 32'h0000_0004);
        wr(`RTC_OFF_RUN, 32'h0000_0000);
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // main sequence
    initial
    begin
        reset     = 1'b1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        pulse_sel = 2'h0;
        pulse_go  = 1'b0;
        step_go   = 1'b0;
        step_up   = 1'b0;
        z_go      = 1'b0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        reset_values();
        timer_reload();
        zero_count();
        event_sources();
        quadrature();
        two_phase_normal();
        gate_and_dir_pin();
        summarize();
    end

    // watchdog against a hang
    initial
    begin
        repeat (40000) @(posedge core_clk);
        n_mismatch++;
        summarize();
    end
endmodule // test_reload_timer_event_counter
